// [hw/instr_exec.sv]
// Executes a subset of an 8-bit core's instructions on a 128-word file,
// an accumulator, a program counter, a return stack and a watchdog.
// Assumes one AXI4-Lite master on core_clk; software issues instructions
// by writing the command register.
//
// What this block does
// - AND accumulator with file, d selects destination.
// - Tested bit set: discard next, two cycles.
// - Tested bit clear: next executes, flags untouched.
// - Kick clears watchdog counter and prescaler.
// - Kick sets expired and sleep flags.
// - Call pushes program counter plus one.
// - Call loads immediate and page latch bits.
// - Call takes two cycles, flags untouched.
// - Invert file into accumulator or file.
// - Clear file writes zero, sets zero flag.
// - Decrement file into accumulator or file.
// - Clear accumulator writes zero, sets zero flag.
// - Counter change or true test: extra no-op cycle.
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none

module instr_exec
  import exec_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp
);

  //////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge of a write into an old word.
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == A_CMD || a == A_ACC || a == A_STAT || a == A_PAGE ||
           a == A_PC || a == A_FADDR || a == A_FDATA || a == A_WDOG ||
           a == A_STK;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave state.
  logic        aw_held_reg;
  logic [7:0]  awaddr_reg;
  logic        w_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  // Core state.
  logic [31:0] cmd_reg;
  logic [7:0]  acc_reg;
  logic [7:0]  page_reg;
  logic [12:0] pc_reg;
  logic [6:0]  faddr_reg;
  logic        zero_reg;
  logic        wdexp_reg;
  logic        sleep_reg;
  logic        busy_reg;
  logic        skip_reg;
  logic [7:0]  wd_cnt_reg;
  logic [7:0]  wd_pre_reg;
  logic [2:0]  sp_reg;
  logic [7:0]  file_mem [FILE_WORDS];
  logic [12:0] stack_mem [STACK_DEPTH];

  //////////////////////////////////////////////////////////////////////////////
  // Bus handshakes and decode.
  wire        wr_fire = aw_held_reg && w_held_reg;
  wire        ar_fire = arvalid && arready;
  wire        wr_ok   = mapped(awaddr_reg);
  wire [31:0] cmd_new = merge(cmd_reg, wdata_reg, wstrb_reg);
  wire        cmd_go  = wr_fire && awaddr_reg == A_CMD;
  wire [31:0] acc_w   = merge({24'h000000, acc_reg}, wdata_reg, wstrb_reg);
  wire [31:0] page_w  = merge({24'h000000, page_reg}, wdata_reg, wstrb_reg);
  wire [31:0] fa_w    = merge({25'h0000000, faddr_reg}, wdata_reg,
                              wstrb_reg);
  wire [7:0]  fdata   = file_mem[faddr_reg];
  wire [31:0] fd_w    = merge({24'h000000, fdata}, wdata_reg, wstrb_reg);
  wire        acc_wr  = wr_fire && awaddr_reg == A_ACC;
  wire        page_wr = wr_fire && awaddr_reg == A_PAGE;
  wire        fa_wr   = wr_fire && awaddr_reg == A_FADDR;
  wire        fd_wr   = wr_fire && awaddr_reg == A_FDATA;

  assign awready = !aw_held_reg && !bvalid_reg;
  assign wready  = !w_held_reg && !bvalid_reg;
  assign arready = !rvalid_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign rvalid  = rvalid_reg;
  assign rdata   = rdata_reg;
  assign rresp   = rresp_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Instruction decode and datapath.
  wire op_e   op     = op_e'(cmd_new[CMD_OP_LSB +: 4]);
  wire        dsel   = cmd_new[CMD_D_BIT];
  wire [2:0]  bsel   = cmd_new[CMD_B_LSB +: 3];
  wire [6:0]  fsel   = cmd_new[CMD_F_LSB +: 7];
  wire [10:0] kimm   = cmd_new[CMD_K_LSB +: 11];
  wire [7:0]  fval   = file_mem[fsel];
  wire        is_fd  = op == OP_AND || op == OP_INV || op == OP_DEC;
  logic [7:0] result;

  always_comb begin
    case (op)
      OP_AND:  result = acc_reg & fval;
      OP_INV:  result = ~fval;
      OP_DEC:  result = fval - 8'h01;
      default: result = 8'h00;
    endcase
  end

  wire to_file = (is_fd && dsel) || op == OP_CLR_FILE;
  wire to_acc  = (is_fd && !dsel) || op == OP_CLR_ACC;
  wire z_upd   = is_fd || op == OP_CLR_FILE || op == OP_CLR_ACC;
  wire z_val   = result == 8'h00;
  wire skip    = op == OP_BSKIP && fval[bsel];
  wire is_call = op == OP_CALL;
  wire kick    = cmd_go && op == OP_KICK;
  wire [12:0] pc_inc  = 13'(pc_reg + 13'h0001);
  wire [12:0] pc_skip = 13'(pc_reg + 13'h0002);
  wire [12:0] pc_call = {page_reg[4:3], kimm};
  wire [2:0]  sp_top  = 3'(sp_reg - 3'h1);
  wire        wd_wrap = wd_pre_reg == 8'hFF;

  //////////////////////////////////////////////////////////////////////////////
  // Read mux.
  logic [31:0] rd_mux;
  always_comb begin
    case (araddr)
      A_CMD:   rd_mux = cmd_reg;
      A_ACC:   rd_mux = {24'h000000, acc_reg};
      A_STAT:  rd_mux = {27'h0000000, skip_reg, busy_reg, wdexp_reg,
                         sleep_reg, zero_reg};
      A_PAGE:  rd_mux = {24'h000000, page_reg};
      A_PC:    rd_mux = {19'h00000, pc_reg};
      A_FADDR: rd_mux = {25'h0000000, faddr_reg};
      A_FDATA: rd_mux = {24'h000000, fdata};
      A_WDOG:  rd_mux = {16'h0000, wd_pre_reg, wd_cnt_reg};
      A_STK:   rd_mux = {13'h0000, sp_reg, 3'h0, stack_mem[sp_top]};
      default: rd_mux = 32'h00000000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave registers.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= 8'h00;
      w_held_reg  <= 1'b0;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= wdata;
        wstrb_reg  <= wstrb;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid_reg <= 1'b0;
      end
      if (ar_fire) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_mux;
        rresp_reg  <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Software-visible registers and the one-cycle no-op slot.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cmd_reg   <= 32'h00000000;
      acc_reg   <= ACC_RST;
      page_reg  <= PAGE_RST;
      faddr_reg <= FADDR_RST;
      zero_reg  <= 1'b0;
      busy_reg  <= 1'b0;
      skip_reg  <= 1'b0;
    end else begin
      busy_reg <= cmd_go && (skip || is_call);
      if (cmd_go) begin
        cmd_reg  <= cmd_new;
        skip_reg <= skip;
        if (to_acc) begin
          acc_reg <= result;
        end
        if (z_upd) begin
          zero_reg <= z_val;
        end
      end else if (acc_wr) begin
        acc_reg <= acc_w[7:0];
      end
      if (page_wr) begin
        page_reg <= page_w[7:0];
      end
      if (fa_wr) begin
        faddr_reg <= fa_w[6:0];
      end
    end
  end

  // The file has no reset; software must clear what it relies on.
  always_ff @(posedge core_clk) begin
    if (cmd_go && to_file) begin
      file_mem[fsel] <= result;
    end else if (fd_wr) begin
      file_mem[faddr_reg] <= fd_w[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Program counter and return stack. The stack wraps when over-filled,
  // dropping the oldest return address, as a fixed-depth core does.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pc_reg <= PC_RST;
      sp_reg <= 3'h0;
    end else if (cmd_go) begin
      if (is_call) begin
        pc_reg <= pc_call;
        sp_reg <= 3'(sp_reg + 3'h1);
      end else if (skip) begin
        pc_reg <= pc_skip;
      end else begin
        pc_reg <= pc_inc;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (cmd_go && is_call) begin
      stack_mem[sp_reg] <= pc_inc;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog. A kick in the same cycle as expiry wins, since the count it
  // restarts would otherwise report a timeout that software just answered.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wd_pre_reg <= 8'h00;
      wd_cnt_reg <= 8'h00;
      wdexp_reg  <= FLAG_RST;
      sleep_reg  <= FLAG_RST;
    end else if (kick) begin
      wd_pre_reg <= 8'h00;
      wd_cnt_reg <= 8'h00;
      wdexp_reg  <= 1'b1;
      sleep_reg  <= 1'b1;
    end else begin
      wd_pre_reg <= 8'(wd_pre_reg + 8'h01);
      if (wd_wrap) begin
        wd_cnt_reg <= 8'(wd_cnt_reg + 8'h01);
        if (wd_cnt_reg == 8'hFF) begin
          wdexp_reg <= 1'b0;
        end
      end
    end
  end

endmodule

`default_nettype wire

// [include/exec_pkg.sv]
// Constants, register map and operation codes of the instruction executor.
// Assumes a 32-bit AXI4-Lite master and byte addresses of eight bits.
`default_nettype none
package exec_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [7:0] A_CMD   = 8'h00;
  localparam logic [7:0] A_ACC   = 8'h04;
  localparam logic [7:0] A_STAT  = 8'h08;
  localparam logic [7:0] A_PAGE  = 8'h0C;
  localparam logic [7:0] A_PC    = 8'h10;
  localparam logic [7:0] A_FADDR = 8'h14;
  localparam logic [7:0] A_FDATA = 8'h18;
  localparam logic [7:0] A_WDOG  = 8'h1C;
  localparam logic [7:0] A_STK   = 8'h20;

  //////////////////////////////////////////////////////////////////////////////
  // Command word fields.
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_D_BIT  = 4;
  localparam int CMD_B_LSB  = 5;
  localparam int CMD_F_LSB  = 8;
  localparam int CMD_K_LSB  = 16;

  // Status word fields.
  localparam int ST_ZERO  = 0;
  localparam int ST_SLEEP = 1;
  localparam int ST_WDEXP = 2;
  localparam int ST_BUSY  = 3;
  localparam int ST_SKIP  = 4;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values and sizes.
  localparam logic [7:0]  ACC_RST  = 8'h00;
  localparam logic [7:0]  PAGE_RST = 8'h00;
  localparam logic [12:0] PC_RST   = 13'h0000;
  localparam logic [6:0]  FADDR_RST = 7'h00;
  localparam logic        FLAG_RST = 1'b1;
  localparam int          STACK_DEPTH = 8;
  localparam int          FILE_WORDS  = 128;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    OP_NOP      = 4'b0000,
    OP_AND      = 4'b0001,
    OP_BSKIP    = 4'b0010,
    OP_KICK     = 4'b0011,
    OP_CALL     = 4'b0100,
    OP_INV      = 4'b0101,
    OP_CLR_FILE = 4'b0110,
    OP_DEC      = 4'b0111,
    OP_CLR_ACC  = 4'b1000
  } op_e;

endpackage

`default_nettype wire

// [verif/instr_exec_checker.sv]
// Bus protocol checker for the instruction executor.
// Assumes it is bound to instr_exec and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module instr_exec_checker
  import exec_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [7:0]  araddr,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp
);
  default clocking dcb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  AST_B_LAT: assert property (awvalid && awready && wvalid && wready
    |-> ##[1:3] bvalid) else $error("write response late");
  AST_B_HOLD: assert property (bvalid && !bready
    |=> bvalid && $stable(bresp)) else $error("write response dropped");
  AST_R_LAT: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  AST_R_HOLD: assert property (rvalid && !rready
    |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped");
  AST_AR_RDY: assert property (arready == !rvalid)
    else $error("read address ready wrong");
  AST_W_BLK: assert property (bvalid |-> !awready && !wready)
    else $error("write taken during response");
  AST_R_ACC: assert property (arvalid && arready && araddr == A_ACC
    |=> rresp == RESP_OKAY && rdata[31:8] == 24'h000000)
    else $error("accumulator read malformed");
  AST_R_UNMAP: assert property (arvalid && arready && araddr == 8'h40
    |=> rresp == RESP_SLVERR && rdata == 32'h00000000)
    else $error("unmapped read not refused");
  cover property (bvalid && bready);
  cover property (rvalid && rready);
  cover property (rvalid && rresp == RESP_SLVERR);
endmodule
bind instr_exec instr_exec_checker chk (.core_clk, .rstn, .awvalid,
  .awready, .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid,
  .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
`default_nettype wire

// [verif/test_cpu_instruction_subset_exec.sv]
// Self-checking bench for the instruction executor.
// Assumes exec_pkg, instr_exec and the bus checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_cpu_instruction_subset_exec
  import exec_pkg::*;
;
  logic        core_clk, rstn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [1:0]  bresp, rresp, rr, br;
  logic [12:0] pc0;
  int          n_fail, n_tests;
  instr_exec uut (.core_clk(core_clk), .rstn(rstn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////
  task automatic give_verdict;
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic ck(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Each handshake is judged at the rising edge that completes it; one idle
  // edge follows so that the next call never re-drives a line in that step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    br = bresp;
    bready <= 1'b0;
    @(posedge core_clk);
    if (i == 50) begin
      n_fail++;
      give_verdict;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    int i;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rv = rdata;
    rr = rresp;
    rready <= 1'b0;
    @(posedge core_clk);
    if (i == 50) begin
      n_fail++;
      give_verdict;
    end
  endtask
  task automatic op(input logic [3:0] o, input logic d, input logic [2:0] b,
                    input logic [6:0] f);
    wr(A_CMD, {17'h00000, f, b, d, o});
  endtask
  task automatic setf(input logic [6:0] f, input logic [7:0] v);
    wr(A_FADDR, {25'h0000000, f});
    wr(A_FDATA, {24'h000000, v});
  endtask
  task automatic getf(input logic [6:0] f);
    wr(A_FADDR, {25'h0000000, f});
    rd(A_FDATA);
  endtask
  task automatic zck(input logic e);
    rd(A_STAT);
    ck("zero flag", 32'(rv[ST_ZERO]), 32'(e));
  endtask
  ////////////////////////////////////////
  task automatic t_alu;
    rd(A_STAT);
    ck("status at reset", rv, 32'h00000006);
    setf(7'h05, 8'h3C);
    wr(A_ACC, 32'h0000000F);
    op(OP_AND, 1'b0, 3'h0, 7'h05);
    rd(A_ACC);
    ck("and to accum", rv, 32'h0000000C);
    zck(1'b0);
    wr(A_ACC, 32'h000000C0);
    op(OP_AND, 1'b1, 3'h0, 7'h05);
    getf(7'h05);
    ck("and to file", rv, 32'h00000000);
    zck(1'b1);
    setf(7'h09, 8'h5A);
    op(OP_INV, 1'b1, 3'h0, 7'h09);
    getf(7'h09);
    ck("invert to file", rv, 32'h000000A5);
    zck(1'b0);
    setf(7'h7F, 8'h01);
    op(OP_DEC, 1'b1, 3'h0, 7'h7F);
    getf(7'h7F);
    ck("decrement to file", rv, 32'h00000000);
    zck(1'b1);
    op(OP_DEC, 1'b0, 3'h0, 7'h7F);
    rd(A_ACC);
    ck("decrement to accum", rv, 32'h000000FF);
    zck(1'b0);
    op(OP_CLR_ACC, 1'b0, 3'h0, 7'h00);
    rd(A_ACC);
    ck("clear accum", rv, 32'h00000000);
    zck(1'b1);
    setf(7'h7F, 8'h33);
    op(OP_INV, 1'b0, 3'h0, 7'h7F);
    rd(A_ACC);
    ck("invert to accum", rv, 32'h000000CC);
    zck(1'b0);
    op(OP_CLR_FILE, 1'b0, 3'h0, 7'h7F);
    getf(7'h7F);
    ck("clear file", rv, 32'h00000000);
    zck(1'b1);
  endtask
  task automatic t_skip;
    setf(7'h03, 8'h80);
    for (int b = 6; b < 8; b++) begin
      rd(A_PC);
      pc0 = rv[12:0];
      // The status read is taken in the one cycle after the perform edge.
      fork
        op(OP_BSKIP, 1'b0, 3'(b), 7'h03);
        begin
          repeat (2) @(posedge core_clk);
          rd(A_STAT);
        end
      join
      ck("no-op slot", 32'(rv[ST_BUSY]), 32'(b == 7));
      rd(A_PC);
      ck("pc after test", rv, 32'(pc0 + 13'(b - 5)));
      rd(A_STAT);
      ck("skip taken", 32'(rv[ST_SKIP]), 32'(b == 7));
      ck("zero kept", 32'(rv[ST_ZERO]), 32'h1);
    end
  endtask
  task automatic t_call;
    wr(A_PAGE, 32'h000000EF);
    rd(A_PC);
    pc0 = rv[12:0];
    fork
      wr(A_CMD, {5'h00, 11'h2AA, 16'h0004});
      begin
        repeat (2) @(posedge core_clk);
        rd(A_STAT);
      end
    join
    ck("call no-op slot", 32'(rv[ST_BUSY]), 32'h1);
    rd(A_PC);
    ck("call target", rv, 32'h00000AAA);
    rd(A_STK);
    ck("return address", 32'(rv[12:0]), 32'(pc0 + 13'h1));
    ck("stack depth", 32'(rv[18:16]), 32'h1);
    rd(A_STAT);
    ck("call flags", 32'(rv[2:0]), 32'h7);
    wr(A_PC, 32'h00000123);
    rd(A_PC);
    ck("pc read-only", rv, 32'h00000AAA);
    rd(8'h40);
    ck("unmapped read", {rr, rv[29:0]}, {RESP_SLVERR, 30'h0});
    wr(8'h40, 32'h00000001);
    ck("unmapped write", 32'(br), 32'(RESP_SLVERR));
  endtask
  // A full watchdog period runs here, which dominates the run time.
  task automatic t_kick;
    op(OP_KICK, 1'b0, 3'h0, 7'h00);
    repeat (66000) @(posedge core_clk);
    rd(A_STAT);
    ck("expiry", 32'(rv[ST_WDEXP]), 32'h0);
    op(OP_KICK, 1'b0, 3'h0, 7'h00);
    rd(A_STAT);
    ck("kick flags", 32'(rv[2:1]), 32'h3);
    rd(A_WDOG);
    ck("watchdog count", 32'(rv[7:0]), 32'h0);
    ck("prescaler", 32'(rv[15:8] < 8'h10), 32'h1);
  endtask
  ////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    n_fail = 0;
    n_tests = 0;
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    t_alu;
    t_skip;
    t_call;
    t_kick;
    give_verdict;
  end
endmodule
`default_nettype wire
